/* File: rtl/alu_exec_pkg.sv */
package alu_exec_pkg;
    // =========================================
    // Widths and memory layout
    // =========================================
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 8;
    localparam int BANK_W  = 1;
    localparam int MEM_AW  = BANK_W + ADDR_W;
    localparam int ROM_W   = 16;
    localparam int PTR_W   = 16;

    // =========================================
    // System register locations in bank 0
    // =========================================
    localparam logic [7:0] SYSREG_LO = 8'h80;
    localparam logic [7:0] SYSREG_HI = 8'h87;
    localparam logic [7:0] R_ADDR    = 8'h82;
    localparam logic [7:0] Z_ADDR    = 8'h83;
    localparam logic [7:0] Y_ADDR    = 8'h84;

    // =========================================
    // Reset values
    // =========================================
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic       CARRY_RST = 1'b0;
    localparam logic [7:0] MEM_RST   = 8'h00;

    // =========================================
    // Operations
    // =========================================
    typedef enum logic [4:0] {
        OP_NOP        = 5'h00,
        OP_MOV_A_IMM  = 5'h01,
        OP_BANK0_MOVE = 5'h02,
        OP_SWAP_AM    = 5'h03,
        OP_B0_SWAP    = 5'h04,
        OP_ROM_READ   = 5'h05,
        OP_ADC_AM     = 5'h06,
        OP_ADC_MA     = 5'h07,
        OP_ADD_AM     = 5'h08,
        OP_ADD_MA     = 5'h09,
        OP_B0_ADD_MA  = 5'h0A,
        OP_ADD_AI     = 5'h0B,
        OP_SWB_AM     = 5'h0C,
        OP_SWB_MA     = 5'h0D,
        OP_SUB_AM     = 5'h0E,
        OP_SUB_MA     = 5'h0F,
        OP_SUB_AI     = 5'h10,
        OP_AND_AM     = 5'h11,
        OP_AND_MA     = 5'h12,
        OP_AND_AI     = 5'h13,
        OP_OR_AM      = 5'h14,
        OP_OR_MA      = 5'h15,
        OP_OR_AI      = 5'h16
    } op_e;

    typedef enum logic [2:0] {
        ALU_PASS = 3'h0,
        ALU_ADD  = 3'h1,
        ALU_SUB  = 3'h2,
        ALU_AND  = 3'h3,
        ALU_OR   = 3'h4,
        ALU_SWAP = 3'h5
    } alu_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_ROM  = 1'b1
    } state_e;

    typedef struct packed {
        op_e                op;
        logic [BANK_W-1:0]  bank;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  imm;
    } req_s;

    typedef struct packed {
        alu_e alu;
        logic use_imm;
        logic bank0;
        logic use_c;
        logic wr_c;
        logic wr_a;
        logic wr_m;
    } dec_s;
endpackage

/* File: rtl/alu_exec.sv */
`timescale 1ns/1ns
// Function
// RULE1: Bank-0 immediate store writes only addresses 0x80 to 0x87.
// RULE2: Move-immediate loads the literal straight into the accumulator.
// RULE3: Exchange swaps accumulator and memory byte; bank-0 form ignores bank.
// RULE4: Table read fetches ROM at Y,Z into R and accumulator.
// RULE5: Add-with-carry sums A, M and carry; carry shows overflow.
// RULE6: Add forms sum A with literal or memory; carry shows overflow.
// RULE7: Bank-0 add writes A plus bank-0 byte back; carry updated.
// RULE8: Subtract-with-borrow does A minus M minus inverted carry.
// RULE9: Subtract clears carry on borrow, sets it otherwise.
// RULE10: AND and OR combine A with memory or literal.
module alu_exec (
    input  wire logic                            clock,
    input  wire logic                            rst_b,
    input  wire logic                            req_valid,
    input  wire alu_exec_pkg::req_s              req,
    input  wire logic [alu_exec_pkg::ROM_W-1:0]  rom_data,
    input  wire logic [alu_exec_pkg::MEM_AW-1:0] dbg_addr,
    output logic                                 busy,
    output logic [alu_exec_pkg::DATA_W-1:0]      acc,
    output logic                                 carry,
    output logic                                 rom_rd,
    output logic [alu_exec_pkg::PTR_W-1:0]       rom_addr,
    output logic                                 refused,
    output logic [alu_exec_pkg::DATA_W-1:0]      dbg_data
);
    localparam int DEPTH = 2 ** alu_exec_pkg::MEM_AW;

    // =========================================
    // Decode
    // =========================================
    function automatic alu_exec_pkg::dec_s decode(
        input alu_exec_pkg::op_e op
    );
        alu_exec_pkg::dec_s d;
        d = '0;
        unique case (op)
            alu_exec_pkg::OP_MOV_A_IMM: begin
                d.use_imm = 1'b1;
                d.wr_a    = 1'b1;
            end
            alu_exec_pkg::OP_BANK0_MOVE: begin
                d.use_imm = 1'b1;
                d.bank0   = 1'b1;
                d.wr_m    = 1'b1;
            end
            alu_exec_pkg::OP_SWAP_AM, alu_exec_pkg::OP_B0_SWAP: begin
                d.alu   = alu_exec_pkg::ALU_SWAP;
                d.bank0 = (op == alu_exec_pkg::OP_B0_SWAP);
                d.wr_a  = 1'b1;
                d.wr_m  = 1'b1;
            end
            alu_exec_pkg::OP_ADC_AM, alu_exec_pkg::OP_ADC_MA,
            alu_exec_pkg::OP_ADD_AM, alu_exec_pkg::OP_ADD_MA,
            alu_exec_pkg::OP_B0_ADD_MA, alu_exec_pkg::OP_ADD_AI: begin
                d.alu     = alu_exec_pkg::ALU_ADD;
                d.use_c   = (op == alu_exec_pkg::OP_ADC_AM)
                          | (op == alu_exec_pkg::OP_ADC_MA);
                d.use_imm = (op == alu_exec_pkg::OP_ADD_AI);
                d.bank0   = (op == alu_exec_pkg::OP_B0_ADD_MA);
                d.wr_m    = (op == alu_exec_pkg::OP_ADC_MA)
                          | (op == alu_exec_pkg::OP_ADD_MA)
                          | (op == alu_exec_pkg::OP_B0_ADD_MA);
                d.wr_a    = ~d.wr_m;
                d.wr_c    = 1'b1;
            end
            alu_exec_pkg::OP_SWB_AM, alu_exec_pkg::OP_SWB_MA,
            alu_exec_pkg::OP_SUB_AM, alu_exec_pkg::OP_SUB_MA,
            alu_exec_pkg::OP_SUB_AI: begin
                d.alu     = alu_exec_pkg::ALU_SUB;
                d.use_c   = (op == alu_exec_pkg::OP_SWB_AM)
                          | (op == alu_exec_pkg::OP_SWB_MA);
                d.use_imm = (op == alu_exec_pkg::OP_SUB_AI);
                d.wr_m    = (op == alu_exec_pkg::OP_SWB_MA)
                          | (op == alu_exec_pkg::OP_SUB_MA);
                d.wr_a    = ~d.wr_m;
                d.wr_c    = 1'b1;
            end
            alu_exec_pkg::OP_AND_AM, alu_exec_pkg::OP_AND_MA,
            alu_exec_pkg::OP_AND_AI: begin
                d.alu     = alu_exec_pkg::ALU_AND;
                d.use_imm = (op == alu_exec_pkg::OP_AND_AI);
                d.wr_m    = (op == alu_exec_pkg::OP_AND_MA);
                d.wr_a    = ~d.wr_m;
            end
            alu_exec_pkg::OP_OR_AM, alu_exec_pkg::OP_OR_MA,
            alu_exec_pkg::OP_OR_AI: begin
                d.alu     = alu_exec_pkg::ALU_OR;
                d.use_imm = (op == alu_exec_pkg::OP_OR_AI);
                d.wr_m    = (op == alu_exec_pkg::OP_OR_MA);
                d.wr_a    = ~d.wr_m;
            end
            default: d = '0;
        endcase
        return d;
    endfunction

    // =========================================
    // State
    // =========================================
    alu_exec_pkg::state_e        state_reg;
    logic [7:0]                  mem [DEPTH];
    logic [7:0]                  acc_reg;
    logic                        carry_reg;
    logic                        rom_rd_reg;
    logic [15:0]                 rom_addr_reg;
    logic                        refused_reg;
    logic [7:0]                  dbg_reg;

    // Request acceptance and operand selection
    wire                      take    = req_valid
                                      & (state_reg == alu_exec_pkg::ST_IDLE);
    wire alu_exec_pkg::dec_s  dec     = decode(req.op);
    wire                      is_rom  = req.op == alu_exec_pkg::OP_ROM_READ;
    wire                      is_b0mv = req.op == alu_exec_pkg::OP_BANK0_MOVE;
    wire [8:0]                wa      = dec.bank0 ? {1'b0, req.addr}   // RULE3
                                                  : {req.bank, req.addr};
    wire [7:0]                mem_q   = mem[wa];
    wire [7:0]                opnd    = dec.use_imm ? req.imm : mem_q;
    wire                      sysreg  = (req.addr >= alu_exec_pkg::SYSREG_LO)
                                      & (req.addr <= alu_exec_pkg::SYSREG_HI);
    wire                      bad_dst = is_b0mv & ~sysreg;         // RULE1

    // Arithmetic with carry in and active-low borrow
    wire [8:0] sum  = {1'b0, acc_reg} + {1'b0, opnd}
                    + {8'h00, dec.use_c & carry_reg};              // RULE5
    wire [8:0] diff = {1'b0, acc_reg} - {1'b0, opnd}
                    - {8'h00, dec.use_c & ~carry_reg};             // RULE8
    wire [7:0] res  = (dec.alu == alu_exec_pkg::ALU_ADD) ? sum[7:0]  // RULE6
                    : (dec.alu == alu_exec_pkg::ALU_SUB) ? diff[7:0] // RULE9
                    : (dec.alu == alu_exec_pkg::ALU_AND) ? acc_reg & opnd
                    : (dec.alu == alu_exec_pkg::ALU_OR)  ? acc_reg | opnd
                    : opnd;                                          // RULE10
    wire       swap = dec.alu == alu_exec_pkg::ALU_SWAP;
    wire [7:0] a_wd = swap ? mem_q : res;                            // RULE3
    wire [7:0] m_wd = swap ? acc_reg : res;
    wire       c_wd = (dec.alu == alu_exec_pkg::ALU_ADD) ? sum[8]
                                                         : ~diff[8];
    wire       m_we = take & dec.wr_m & ~bad_dst;                    // RULE1
    wire       rom_done = state_reg == alu_exec_pkg::ST_ROM;
    wire [15:0] yz  = {mem[{1'b0, alu_exec_pkg::Y_ADDR}],
                       mem[{1'b0, alu_exec_pkg::Z_ADDR}]};

    // Sequencer for the two-cycle table read
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= alu_exec_pkg::ST_IDLE;
            rom_rd_reg   <= 1'b0;
            rom_addr_reg <= 16'h0000;
        end else begin
            state_reg  <= (take & is_rom) ? alu_exec_pkg::ST_ROM
                                          : alu_exec_pkg::ST_IDLE;
            rom_rd_reg <= take & is_rom;
            if (take & is_rom) begin
                rom_addr_reg <= yz;                                // RULE4
            end
        end
    end

    // Accumulator, carry and refusal flag
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_reg     <= alu_exec_pkg::ACC_RST;
            carry_reg   <= alu_exec_pkg::CARRY_RST;
            refused_reg <= 1'b0;
        end else begin
            refused_reg <= take & bad_dst;
            if (rom_done) begin
                acc_reg <= rom_data[7:0];                          // RULE4
            end else if (take & dec.wr_a) begin
                acc_reg <= a_wd;                                   // RULE2
            end
            if (take & dec.wr_c) begin
                carry_reg <= c_wd;                                 // RULE5
            end
        end
    end

    // Data memory, including R, Y and Z in bank 0
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= alu_exec_pkg::MEM_RST;
            end
            dbg_reg <= 8'h00;
        end else begin
            dbg_reg <= mem[dbg_addr];
            if (rom_done) begin
                mem[{1'b0, alu_exec_pkg::R_ADDR}] <= rom_data[15:8]; // RULE4
            end else if (m_we) begin
                mem[wa] <= m_wd;                                   // RULE7
            end
        end
    end

    assign busy     = rom_rd_reg;
    assign acc      = acc_reg;
    assign carry    = carry_reg;
    assign rom_rd   = rom_rd_reg;
    assign rom_addr = rom_addr_reg;
    assign refused  = refused_reg;
    assign dbg_data = dbg_reg;

    // =========================================
    // Assertions
    // =========================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_rom_req;
        take && is_rom;
    endsequence

    sequence s_rom_fetch;
        rom_rd_reg && rom_addr_reg == $past(yz) ##1 !rom_rd_reg;
    endsequence

    imm_load_a: assert property ( // RULE2
        take && req.op == alu_exec_pkg::OP_MOV_A_IMM
        |=> acc == $past(req.imm))
        else $error("immediate not loaded into accumulator");

    sysreg_only_a: assert property ( // RULE1
        take && is_b0mv
        |=> refused == !$past(sysreg) &&
            (refused || mem[$past(wa)] == $past(req.imm)))
        else $error("bank-0 store destination check wrong");

    exchange_swap_a: assert property ( // RULE3
        take && swap
        |=> acc == $past(mem_q) && mem[$past(wa)] == $past(acc_reg))
        else $error("exchange did not swap");

    rom_read_a: assert property ( // RULE4
        s_rom_req |=> s_rom_fetch ##0
        (acc == $past(rom_data[7:0]) &&
         mem[{1'b0, alu_exec_pkg::R_ADDR}] == $past(rom_data[15:8])))
        else $error("table read result wrong");

    adc_carry_a: assert property ( // RULE5
        take && req.op == alu_exec_pkg::OP_ADC_AM
        |=> {carry, acc} == $past(9'(acc_reg) + 9'(mem_q)
                                  + 9'(carry_reg)))
        else $error("add with carry wrong");

    add_imm_a: assert property ( // RULE6
        take && req.op == alu_exec_pkg::OP_ADD_AI
        |=> {carry, acc} == $past(9'(acc_reg) + 9'(req.imm)))
        else $error("add immediate wrong");

    bank0_add_a: assert property ( // RULE7
        take && req.op == alu_exec_pkg::OP_B0_ADD_MA
        |=> {carry, mem[{1'b0, $past(req.addr)}]} ==
            $past(9'(acc_reg) + 9'(mem[{1'b0, req.addr}])))
        else $error("bank-0 add wrong");

    swb_borrow_a: assert property ( // RULE8
        take && req.op == alu_exec_pkg::OP_SWB_AM
        |=> acc == $past(acc_reg - mem_q - 8'(!carry_reg)) &&
            carry == $past(9'(acc_reg) >= 9'(mem_q) + 9'(!carry_reg)))
        else $error("subtract with borrow wrong");

    sub_borrow_a: assert property ( // RULE9
        take && req.op == alu_exec_pkg::OP_SUB_AI
        |=> acc == $past(acc_reg - req.imm) &&
            carry == $past(acc_reg >= req.imm))
        else $error("subtract immediate wrong");

    logic_ops_a: assert property ( // RULE10
        take && (req.op == alu_exec_pkg::OP_AND_AM ||
                 req.op == alu_exec_pkg::OP_OR_AI)
        |=> acc == ($past(req.op) == alu_exec_pkg::OP_AND_AM
                    ? $past(acc_reg & mem_q)
                    : $past(acc_reg | req.imm)) && $stable(carry))
        else $error("logic operation wrong");

    adc_to_mem_a: assert property ( // RULE5
        take && req.op == alu_exec_pkg::OP_ADC_MA
        |=> {carry, mem[$past(wa)]} == $past(9'(acc_reg) + 9'(mem_q)
                                             + 9'(carry_reg)))
        else $error("add with carry to memory wrong");

    add_to_mem_a: assert property ( // RULE6
        take && req.op == alu_exec_pkg::OP_ADD_MA
        |=> {carry, mem[$past(wa)]} == $past(9'(acc_reg) + 9'(mem_q)))
        else $error("add to memory wrong");

    swb_to_mem_a: assert property ( // RULE8
        take && req.op == alu_exec_pkg::OP_SWB_MA
        |=> mem[$past(wa)] == $past(acc_reg - mem_q - 8'(!carry_reg)) &&
            carry == $past(9'(acc_reg) >= 9'(mem_q) + 9'(!carry_reg)))
        else $error("subtract with borrow to memory wrong");

    sub_to_mem_a: assert property ( // RULE9
        take && req.op == alu_exec_pkg::OP_SUB_MA
        |=> mem[$past(wa)] == $past(acc_reg - mem_q) &&
            carry == $past(acc_reg >= mem_q))
        else $error("subtract to memory wrong");

    logic_to_mem_a: assert property ( // RULE10
        take && (req.op == alu_exec_pkg::OP_AND_MA ||
                 req.op == alu_exec_pkg::OP_OR_MA)
        |=> mem[$past(wa)] == ($past(req.op) == alu_exec_pkg::OP_AND_MA
                               ? $past(acc_reg & mem_q)
                               : $past(acc_reg | mem_q)) && $stable(carry))
        else $error("logic operation to memory wrong");
endmodule

/* File: verif/cpu_move_arith_logic_ops_test.sv */
`timescale 1ns/1ns
module cpu_move_arith_logic_ops_test;
    // ==============================================
    // Stimulus and observed signals
    // ==============================================
    logic                                 clock;
    logic                                 rst_b;
    logic                                 req_valid;
    alu_exec_pkg::req_s                   req;
    logic [alu_exec_pkg::ROM_W-1:0]       rom_data;
    logic [alu_exec_pkg::MEM_AW-1:0]      dbg_addr;
    logic                                 busy;
    logic [alu_exec_pkg::DATA_W-1:0]      acc;
    logic                                 carry;
    logic                                 rom_rd;
    logic [alu_exec_pkg::PTR_W-1:0]       rom_addr;
    logic                                 refused;
    logic [alu_exec_pkg::DATA_W-1:0]      dbg_data;
    int                                   failures;
    int                                   checked;
    logic                                 ref1;
    logic                                 rd1;
    logic                                 busy1;
    logic [7:0]                           mem_val;

    alu_exec alu_exec_inst (
        .clock    (clock),
        .rst_b    (rst_b),
        .req_valid(req_valid),
        .req      (req),
        .rom_data (rom_data),
        .dbg_addr (dbg_addr),
        .busy     (busy),
        .acc      (acc),
        .carry    (carry),
        .rom_rd   (rom_rd),
        .rom_addr (rom_addr),
        .refused  (refused),
        .dbg_data (dbg_data)
    );

    // ==============================================
    // Clock
    // ==============================================
    initial clock = 1'b0;
    always #5 clock = ~clock;

    // ==============================================
    // Shared tasks
    // ==============================================
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Carry and difference, carry high when no borrow
    function automatic logic [8:0] sub9(input logic [7:0] a,
                                        input logic [7:0] m,
                                        input logic       cin);
        logic [8:0] d;
        d = {1'b0, a} - {1'b0, m} - {8'h00, ~cin};
        return {~d[8], d[7:0]};
    endfunction

    // One request, then one idle cycle; pulses caught in the cycle after
    task automatic issue(input alu_exec_pkg::op_e o, input logic b,
                         input logic [7:0] a, input logic [7:0] i);
        req       = '{op: o, bank: b, addr: a, imm: i};
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        ref1      = refused;
        rd1       = rom_rd;
        busy1     = busy;
        @(negedge clock);
    endtask

    // Read one data memory byte through the debug port
    task automatic peek(input logic [8:0] idx);
        dbg_addr = idx;
        @(negedge clock);
        mem_val = dbg_data;
    endtask

    // ==============================================
    // Scenarios
    // ==============================================
    // Back-to-back literal load and add, then add without overflow
    task automatic t_move_add();
        req       = '{op: alu_exec_pkg::OP_MOV_A_IMM, bank: 1'b0,
                      addr: 8'h00, imm: 8'hF0};
        req_valid = 1'b1;
        @(negedge clock);
        check(acc, 8'hF0);
        req = '{op: alu_exec_pkg::OP_ADD_AI, bank: 1'b0,
                addr: 8'h00, imm: 8'h20};
        @(negedge clock);
        req_valid = 1'b0;
        check({carry, acc}, 9'h0F0 + 9'h020);
        @(negedge clock);
        issue(alu_exec_pkg::OP_ADD_AI, 1'b0, 8'h00, 8'h05);
        check({carry, acc}, 9'h010 + 9'h005);
    endtask

    // Exchange then arithmetic against a bank-1 byte
    task automatic t_mem_arith();
        issue(alu_exec_pkg::OP_MOV_A_IMM, 1'b0, 8'h00, 8'h3C);
        issue(alu_exec_pkg::OP_SWAP_AM, 1'b1, 8'h10, 8'h00);
        check(acc, alu_exec_pkg::MEM_RST);
        peek(9'h110);
        check(mem_val, 8'h3C);
        issue(alu_exec_pkg::OP_MOV_A_IMM, 1'b0, 8'h00, 8'h30);
        issue(alu_exec_pkg::OP_SUB_AM, 1'b1, 8'h10, 8'h00);
        check({carry, acc}, sub9(8'h30, 8'h3C, 1'b1));
        issue(alu_exec_pkg::OP_SWB_AM, 1'b1, 8'h10, 8'h00);
        check({carry, acc}, sub9(8'hF4, 8'h3C, 1'b0));
        issue(alu_exec_pkg::OP_ADC_AM, 1'b1, 8'h10, 8'h00);
        check({carry, acc}, 9'h0B7 + 9'h03C + 9'h001);
        issue(alu_exec_pkg::OP_ADD_MA, 1'b1, 8'h10, 8'h00);
        peek(9'h110);
        check({carry, mem_val}, 9'h0F4 + 9'h03C);
        issue(alu_exec_pkg::OP_SUB_AI, 1'b0, 8'h00, 8'hF4);
        check({carry, acc}, sub9(8'hF4, 8'hF4, 1'b1));
        issue(alu_exec_pkg::OP_ADC_MA, 1'b1, 8'h10, 8'h00);
        peek(9'h110);
        check({carry, mem_val}, 9'h030 + 9'h001);
        issue(alu_exec_pkg::OP_SWB_MA, 1'b1, 8'h10, 8'h00);
        peek(9'h110);
        check({carry, mem_val}, sub9(8'h00, 8'h31, 1'b0));
        issue(alu_exec_pkg::OP_SUB_MA, 1'b1, 8'h10, 8'h00);
        peek(9'h110);
        check({carry, mem_val}, sub9(8'h00, 8'hCE, 1'b1));
    endtask

    // Bank-0 forms ignore the bank field
    task automatic t_bank0();
        issue(alu_exec_pkg::OP_MOV_A_IMM, 1'b0, 8'h00, 8'h11);
        issue(alu_exec_pkg::OP_B0_SWAP, 1'b1, 8'h20, 8'h00);
        check(acc, 8'h00);
        peek(9'h020);
        check(mem_val, 8'h11);
        peek(9'h120);
        check(mem_val, 8'h00);
        issue(alu_exec_pkg::OP_MOV_A_IMM, 1'b0, 8'h00, 8'hF5);
        issue(alu_exec_pkg::OP_B0_ADD_MA, 1'b1, 8'h20, 8'h00);
        peek(9'h020);
        check({carry, mem_val}, 9'h0F5 + 9'h011);
        peek(9'h120);
        check(mem_val, 8'h00);
    endtask

    // Immediate store only reaches the system register range
    task automatic t_refuse();
        logic [7:0] addrs [4];
        logic       outside;
        addrs = '{8'h7F, 8'h80, 8'h87, 8'h88};
        foreach (addrs[k]) begin
            outside = addrs[k] < 8'h80 || addrs[k] > 8'h87;
            issue(alu_exec_pkg::OP_BANK0_MOVE, 1'b1, addrs[k], 8'hA5);
            check(ref1, outside);
            peek({1'b0, addrs[k]});
            check(mem_val, outside ? 8'h00 : 8'hA5);
        end
    endtask

    // Table read through the Y,Z pointer
    task automatic t_rom();
        issue(alu_exec_pkg::OP_BANK0_MOVE, 1'b0, alu_exec_pkg::Y_ADDR, 8'h12);
        issue(alu_exec_pkg::OP_BANK0_MOVE, 1'b0, alu_exec_pkg::Z_ADDR, 8'h34);
        rom_data = 16'hBE6F;
        issue(alu_exec_pkg::OP_ROM_READ, 1'b0, 8'h00, 8'h00);
        check({rd1, busy1}, 2'h3);
        check(rom_addr, 16'h1234);
        check(acc, 8'h6F);
        peek({1'b0, alu_exec_pkg::R_ADDR});
        check(mem_val, 8'hBE);
    endtask

    // Bitwise forms to accumulator and to memory
    task automatic t_logic();
        issue(alu_exec_pkg::OP_MOV_A_IMM, 1'b0, 8'h00, 8'hC3);
        issue(alu_exec_pkg::OP_AND_AI, 1'b0, 8'h00, 8'h5A);
        check(acc, 8'hC3 & 8'h5A);
        issue(alu_exec_pkg::OP_OR_AI, 1'b0, 8'h00, 8'h0C);
        check(acc, 8'h42 | 8'h0C);
        issue(alu_exec_pkg::OP_OR_MA, 1'b1, 8'h10, 8'h00);
        peek(9'h110);
        check(mem_val, 8'h4E | 8'h32);
        issue(alu_exec_pkg::OP_AND_AM, 1'b0, 8'h20, 8'h00);
        check(acc, 8'h4E & 8'h06);
        issue(alu_exec_pkg::OP_OR_AM, 1'b1, 8'h10, 8'h00);
        check(acc, 8'h06 | 8'h7E);
        issue(alu_exec_pkg::OP_AND_MA, 1'b0, 8'h87, 8'h00);
        peek(9'h087);
        check(mem_val, 8'h7E & 8'hA5);
        check(carry, 1'b1);
    endtask

    // ==============================================
    // Watchdog and main sequence
    // ==============================================
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        results();
    end

    initial begin
        failures  = 0;
        checked   = 0;
        rst_b     = 1'b0;
        req_valid = 1'b0;
        req       = '0;
        rom_data  = 16'h0000;
        dbg_addr  = 9'h000;
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        t_move_add();
        t_mem_arith();
        t_bank0();
        t_refuse();
        t_rom();
        t_logic();
        results();
    end
endmodule
